// file: inc/sensor_cfg_params.svh
// offsets, field positions and reset values of the sensor configuration block
//
// Overview of operation
// R01: bit7 enables packet check, bit6 disables parity
// R02: rstdaa or bus reset restores both check bits
// R03: bit5 read-only shows active bus protocol
// R04: bit4 selects auto or host read pointer
// R05: origin bits 3:2, code 00 is register 49
// R06: host never writes reserved field encodings
// R07: host ends configuration writes with stop
// R08: temperature clear command register at 13h
// R09: write-one wipes the four temperature flags, reads zero
// R10: writing zero leaves temperature flags untouched
// R11: log packet check and parity errors, clear 14h
// R12: error clear works only in i3c mode
// R13: bit1 wipes packet error, bit0 parity error
// R14: writing zero leaves error flags untouched
// R15: host changes burst bit only in i3c
// R16: reserved bits read zero, writes ignored
`ifndef SENSOR_CFG_PARAMS_SVH
`define SENSOR_CFG_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADDR_DEV_CFG 8'h12
`define ADDR_TEMP_CLR 8'h13
`define ADDR_ERR_CLR 8'h14
`define ADDR_CUR_TEMP 8'h31

// ----------------------------------------
// field positions
// ----------------------------------------
`define CFG_PCE_BIT 7
`define CFG_TDIS_BIT 6
`define CFG_PROTO_BIT 5
`define CFG_APE_BIT 4
`define CFG_ORG_HI 3
`define CFG_ORG_LO 2
`define CFG_BURST_BIT 1
`define ERR_PEC_BIT 1
`define ERR_TBIT_BIT 0
`define ORIGIN_CUR_TEMP 2'h0

// ----------------------------------------
// reset values
// ----------------------------------------
`define CFG_RESET 8'h00
`define BYTE_ZERO 8'h00

`endif

// file: inc/sensor_cfg_pkg.sv
// types shared by the sensor configuration block
package sensor_cfg_pkg;

  // ----------------------------------------
  // register port request from the protocol engine
  // ----------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // ----------------------------------------
  // writable configuration fields
  // ----------------------------------------
  typedef struct packed {
    logic packet_check_enable;
    logic tbit_check_disable;
    logic auto_read_pointer_enable;
    logic [1:0] auto_read_pointer_origin;
    logic auto_read_burst_length;
  } cfg_t;

  // ----------------------------------------
  // whole state of the register bank
  // ----------------------------------------
  typedef struct packed {
    cfg_t cfg;
    logic [3:0] temp_wipe;
    logic packet_check_error_flag;
    logic tbit_error_flag;
    logic [7:0] rdata;
    logic rvalid;
    logic [7:0] rd_start;
  } bank_state_t;

endpackage : sensor_cfg_pkg

// file: hw/link_sync.sv
// two-flop synchroniser with toggle-to-pulse conversion
`timescale 1ns/1ns
module link_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] level_o,
  output logic [W-1:0] toggle_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;

  // ----------------------------------------
  // per-bit crossing
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      // first flop feeds only the second
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          meta_r[g] <= 1'b0;
          sync_r[g] <= 1'b0;
          prev_r[g] <= 1'b0;
        end else begin
          meta_r[g] <= async_i[g];
          sync_r[g] <= meta_r[g];
          prev_r[g] <= sync_r[g];
        end
      end
      assign level_o[g] = sync_r[g];
      assign toggle_o[g] = sync_r[g] ^ prev_r[g];
    end
  endgenerate
endmodule : link_sync

// file: hw/sensor_cfg_regs.sv
// configuration and clear-command register bank of the temperature sensor
`timescale 1ns/1ns
`include "sensor_cfg_params.svh"
module sensor_cfg_regs (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire sensor_cfg_pkg::reg_req_t req_i,
  input wire logic [7:0] host_ptr_i,
  input wire logic i3c_mode_i,
  input wire logic rstdaa_tgl_i,
  input wire logic bus_reset_tgl_i,
  input wire logic pec_err_tgl_i,
  input wire logic tbit_err_tgl_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output logic [7:0] read_start_addr_o,
  output logic packet_check_enable_o,
  output logic tbit_check_disable_o,
  output logic auto_read_burst_length_o,
  output logic active_bus_protocol_flag_o,
  output logic wipe_critical_low_flag_o,
  output logic wipe_critical_high_flag_o,
  output logic wipe_low_limit_flag_o,
  output logic wipe_high_limit_flag_o,
  output logic packet_check_error_flag_o,
  output logic tbit_error_flag_o
);
  sensor_cfg_pkg::bank_state_t st_r;
  sensor_cfg_pkg::bank_state_t st_nxt;
  logic [4:0] lvl;
  logic [4:0] tgl;
  logic i3c;
  logic ev_rstdaa;
  logic ev_busrst;
  logic ev_pec;
  logic ev_tbit;
  logic wr_cfg;
  logic wr_tclr;
  logic wr_eclr;
  logic [7:0] cfg_view;

  // ----------------------------------------
  // link-side crossing
  // ----------------------------------------
  // events come as toggles so no pulse is lost to the slower link clock
  link_sync #(
    .W(5)
  ) u_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .async_i({i3c_mode_i, rstdaa_tgl_i, bus_reset_tgl_i, pec_err_tgl_i, tbit_err_tgl_i}),
    .level_o(lvl),
    .toggle_o(tgl)
  );

  assign i3c = lvl[4];
  assign ev_rstdaa = tgl[3];
  assign ev_busrst = tgl[2];
  assign ev_pec = tgl[1];
  assign ev_tbit = tgl[0];

  // ----------------------------------------
  // decode
  // ----------------------------------------
  assign wr_cfg = req_i.wr && (req_i.addr == `ADDR_DEV_CFG);
  assign wr_tclr = req_i.wr && (req_i.addr == `ADDR_TEMP_CLR); // R08
  assign wr_eclr = req_i.wr && (req_i.addr == `ADDR_ERR_CLR);

  always_comb begin
    cfg_view = `BYTE_ZERO; // R16
    cfg_view[`CFG_PCE_BIT] = st_r.cfg.packet_check_enable; // R01
    cfg_view[`CFG_TDIS_BIT] = st_r.cfg.tbit_check_disable; // R01
    cfg_view[`CFG_PROTO_BIT] = i3c; // R03
    cfg_view[`CFG_APE_BIT] = st_r.cfg.auto_read_pointer_enable;
    cfg_view[`CFG_ORG_HI:`CFG_ORG_LO] = st_r.cfg.auto_read_pointer_origin;
    cfg_view[`CFG_BURST_BIT] = st_r.cfg.auto_read_burst_length;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.temp_wipe = 4'h0; // R10
    st_nxt.rvalid = 1'b0;
    if (wr_cfg) begin
      st_nxt.cfg.packet_check_enable = req_i.wdata[`CFG_PCE_BIT]; // R01
      st_nxt.cfg.tbit_check_disable = req_i.wdata[`CFG_TDIS_BIT]; // R01
      st_nxt.cfg.auto_read_pointer_enable = req_i.wdata[`CFG_APE_BIT]; // R04
      st_nxt.cfg.auto_read_pointer_origin = req_i.wdata[`CFG_ORG_HI:`CFG_ORG_LO]; // R05
      st_nxt.cfg.auto_read_burst_length = req_i.wdata[`CFG_BURST_BIT];
    end
    // bus-level reset of the check bits wins over a same-cycle write
    if (ev_rstdaa || ev_busrst) begin
      st_nxt.cfg.packet_check_enable = 1'b0; // R02
      st_nxt.cfg.tbit_check_disable = 1'b0; // R02
    end
    if (wr_tclr) begin
      st_nxt.temp_wipe = req_i.wdata[3:0]; // R09
    end
    if (wr_eclr && i3c) begin // R12
      if (req_i.wdata[`ERR_PEC_BIT]) begin // R14
        st_nxt.packet_check_error_flag = 1'b0; // R13
      end
      if (req_i.wdata[`ERR_TBIT_BIT]) begin // R14
        st_nxt.tbit_error_flag = 1'b0; // R13
      end
    end
    // new error beats a clear in the same cycle
    if (ev_pec) begin
      st_nxt.packet_check_error_flag = 1'b1; // R11
    end
    if (ev_tbit) begin
      st_nxt.tbit_error_flag = 1'b1; // R11
    end
    if (req_i.rd) begin
      st_nxt.rvalid = 1'b1;
      case (req_i.addr)
        `ADDR_DEV_CFG: begin
          st_nxt.rdata = cfg_view;
        end
        default: begin
          st_nxt.rdata = `BYTE_ZERO; // R09 R13 R16
        end
      endcase
    end
    // only origin 00 is defined; reserved codes fall back to it
    if (st_r.cfg.auto_read_pointer_enable) begin
      st_nxt.rd_start = `ADDR_CUR_TEMP; // R04 R05
    end else begin
      st_nxt.rd_start = host_ptr_i; // R04
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rdata_o = st_r.rdata;
  assign rvalid_o = st_r.rvalid;
  assign read_start_addr_o = st_r.rd_start;
  assign packet_check_enable_o = st_r.cfg.packet_check_enable;
  assign tbit_check_disable_o = st_r.cfg.tbit_check_disable;
  assign auto_read_burst_length_o = st_r.cfg.auto_read_burst_length;
  assign active_bus_protocol_flag_o = i3c;
  assign wipe_critical_low_flag_o = st_r.temp_wipe[3];
  assign wipe_critical_high_flag_o = st_r.temp_wipe[2];
  assign wipe_low_limit_flag_o = st_r.temp_wipe[1];
  assign wipe_high_limit_flag_o = st_r.temp_wipe[0];
  assign packet_check_error_flag_o = st_r.packet_check_error_flag;
  assign tbit_error_flag_o = st_r.tbit_error_flag;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_bus_rst;
    ev_rstdaa || ev_busrst;
  endsequence

  sequence s_cfg_wr_only;
    wr_cfg && !ev_rstdaa && !ev_busrst;
  endsequence

  sequence s_cfg_rd;
    req_i.rd && (req_i.addr == `ADDR_DEV_CFG);
  endsequence

  property p_cfg_write;
    @(posedge clk_i) disable iff (!resetn_i)
    s_cfg_wr_only |=> (packet_check_enable_o == $past(req_i.wdata[7])) && (tbit_check_disable_o == $past(req_i.wdata[6]));
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write not stored"); // R01

  property p_bus_rst;
    @(posedge clk_i) disable iff (!resetn_i)
    s_bus_rst |=> !packet_check_enable_o && !tbit_check_disable_o;
  endproperty
  a_bus_rst: assert property (p_bus_rst) else $error("check bits not restored"); // R02

  property p_proto_read;
    @(posedge clk_i) disable iff (!resetn_i)
    s_cfg_rd |=> rvalid_o && (rdata_o[5] == $past(i3c)) && (rdata_o[0] == 1'b0);
  endproperty
  a_proto_read: assert property (p_proto_read) else $error("protocol bit misread"); // R03

  property p_auto_ptr;
    @(posedge clk_i) disable iff (!resetn_i)
    st_r.cfg.auto_read_pointer_enable |=> read_start_addr_o == 8'h31;
  endproperty
  a_auto_ptr: assert property (p_auto_ptr) else $error("auto pointer not 49"); // R05

  property p_host_ptr;
    @(posedge clk_i) disable iff (!resetn_i)
    !st_r.cfg.auto_read_pointer_enable |=> read_start_addr_o == $past(host_ptr_i);
  endproperty
  a_host_ptr: assert property (p_host_ptr) else $error("host pointer not used"); // R04

  property p_temp_wipe;
    @(posedge clk_i) disable iff (!resetn_i)
    wr_tclr |=> ({wipe_critical_low_flag_o, wipe_critical_high_flag_o, wipe_low_limit_flag_o,
      wipe_high_limit_flag_o} == $past(req_i.wdata[3:0])) ##1 (st_r.temp_wipe == 4'h0 || $past(wr_tclr));
  endproperty
  a_temp_wipe: assert property (p_temp_wipe) else $error("wipe pulse wrong"); // R09

  property p_no_wipe;
    @(posedge clk_i) disable iff (!resetn_i)
    !wr_tclr |=> st_r.temp_wipe == 4'h0;
  endproperty
  a_no_wipe: assert property (p_no_wipe) else $error("spurious wipe"); // R10

  property p_err_set;
    @(posedge clk_i) disable iff (!resetn_i)
    ev_pec |=> packet_check_error_flag_o;
  endproperty
  a_err_set: assert property (p_err_set) else $error("packet error not logged"); // R11

  property p_err_i2c;
    @(posedge clk_i) disable iff (!resetn_i)
    (wr_eclr && !i3c && tbit_error_flag_o) |=> tbit_error_flag_o;
  endproperty
  a_err_i2c: assert property (p_err_i2c) else $error("error cleared in i2c"); // R12

  property p_err_clr;
    @(posedge clk_i) disable iff (!resetn_i)
    (wr_eclr && i3c && req_i.wdata[1] && !ev_pec) |=> !packet_check_error_flag_o;
  endproperty
  a_err_clr: assert property (p_err_clr) else $error("packet error not wiped"); // R13

  property p_err_keep;
    @(posedge clk_i) disable iff (!resetn_i)
    (wr_eclr && !req_i.wdata[0] && tbit_error_flag_o) |=> tbit_error_flag_o;
  endproperty
  a_err_keep: assert property (p_err_keep) else $error("parity error lost"); // R14

  property p_rsvd;
    @(posedge clk_i) disable iff (!resetn_i)
    (req_i.rd && req_i.addr != `ADDR_DEV_CFG) |=> rdata_o == 8'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero"); // R16

endmodule : sensor_cfg_regs

// file: tb/host_link_model.sv
// far-side host model: issues link events as toggles on its own link clock
`timescale 1ns/1ns
module host_link_model (
  input wire logic [3:0] ev_i,
  output logic [3:0] tgl_o
);
  logic link_clk;
  // idle level 0 from time zero, so no false toggle is seen after reset
  logic [3:0] tgl_r = 4'h0;
  assign tgl_o = tgl_r;
  // ----------------------------------------
  // 160 ns link clock, phase unrelated to clk_i
  // ----------------------------------------
  initial begin
    link_clk = 1'b0;
    #37;
    forever #80 link_clk = ~link_clk;
  end
  // events leave only on link edges, so spacing is far above two clk cycles
  always @(posedge link_clk) begin
    tgl_r <= ev_i;
  end
endmodule : host_link_model

// file: tb/tb_sensor_cfg_regs.sv
// self-checking bench of the sensor configuration register bank
`timescale 1ns/1ns
module tb_sensor_cfg_regs;
  logic clk_i, resetn_i, i3c_mode_i, rvalid_o, pce_o, tdis_o, burst_o, proto_o, pec_o, tbit_o, pec_m, tbit_m;
  logic [7:0] host_ptr_i, rdata_o, start_o, d, cfg_m;
  logic [3:0] wipe_o, ev, tgl;
  logic [31:0] seed;
  int num_errors, checked;
  sensor_cfg_pkg::reg_req_t req_i;
  // ----------------------------------------
  // design and far side
  // ----------------------------------------
  sensor_cfg_regs DUT (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req_i), .host_ptr_i(host_ptr_i),
    .i3c_mode_i(i3c_mode_i), .rstdaa_tgl_i(tgl[0]), .bus_reset_tgl_i(tgl[1]), .pec_err_tgl_i(tgl[2]),
    .tbit_err_tgl_i(tgl[3]), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .read_start_addr_o(start_o),
    .packet_check_enable_o(pce_o), .tbit_check_disable_o(tdis_o), .auto_read_burst_length_o(burst_o),
    .active_bus_protocol_flag_o(proto_o), .wipe_critical_low_flag_o(wipe_o[3]),
    .wipe_critical_high_flag_o(wipe_o[2]), .wipe_low_limit_flag_o(wipe_o[1]),
    .wipe_high_limit_flag_o(wipe_o[0]), .packet_check_error_flag_o(pec_o), .tbit_error_flag_o(tbit_o));
  host_link_model host (.ev_i(ev), .tgl_o(tgl));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  task automatic st(input string what);
    chk(what, {4'h0, cfg_m[7], cfg_m[6], pec_m, tbit_m}, {4'h0, pce_o, tdis_o, pec_o, tbit_o});
  endtask : st
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    req_i <= '{w, ~w, a, v};
    @(posedge clk_i);
    req_i <= '0;
    // rvalid and wipe pulses stand one cycle: sample right after the taking edge
    #1;
  endtask : acc
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk("rvalid", 8'h01, {7'h0, rvalid_o});
    chk("rdata", e, rdata_o);
  endtask : rd
  task automatic mode(input logic m);
    @(posedge clk_i);
    i3c_mode_i <= m;
    repeat (4) @(posedge clk_i);
    #1;
    chk("protocol", {7'h0, m}, {7'h0, proto_o});
  endtask : mode
  task automatic wcfg(input logic [7:0] v);
    acc(1'b1, 8'h12, v);
    cfg_m = v & 8'hDE;
    st("cfg");
    chk("burst", {7'h0, cfg_m[1]}, {7'h0, burst_o});
    @(posedge clk_i);
    #1;
    chk("start", cfg_m[4] ? 8'h31 : host_ptr_i, start_o);
    rd(8'h12, cfg_m | {2'b0, i3c_mode_i, 5'b0});
  endtask : wcfg
  // bounded wait: link retiming plus sync stays far below 40 cycles
  task automatic fire(input int b);
    int n;
    @(posedge clk_i);
    ev[b] <= ~ev[b];
    if (b < 2) begin
      cfg_m[7:6] = 2'b00;
    end else if (b == 2) begin
      pec_m = 1'b1;
    end else begin
      tbit_m = 1'b1;
    end
    for (n = 0; n < 40 && {pce_o, tdis_o, pec_o, tbit_o} !== {cfg_m[7:6], pec_m, tbit_m}; n++) begin
      @(posedge clk_i);
      #1;
    end
    if (n == 40) begin
      num_errors++;
      $display("MISMATCH event expected settle seen timeout");
      end_of_test();
    end else begin
      st("event");
    end
  endtask : fire
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    resetn_i = 1'b0;
    i3c_mode_i = 1'b0;
    req_i = '0;
    host_ptr_i = 8'h05;
    ev = 4'h0;
    num_errors = 0;
    checked = 0;
    cfg_m = 8'h00;
    pec_m = 1'b0;
    tbit_m = 1'b0;
    seed = 32'h91D9;
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    #1;
    st("reset");
    rd(8'h12, 8'h00);
    // reserved origin codes never sent; burst bit only touched in i3c
    for (int i = 0; i < 16; i++) begin
      if (i == 8) begin
        mode(1'b1);
      end
      seed = xs(seed);
      @(posedge clk_i);
      host_ptr_i <= seed[23:16];
      wcfg(seed[7:0] & (i3c_mode_i ? 8'hF3 : 8'hF1));
    end
    $display("test config done");
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      d = (i == 0) ? 8'h0F : (i == 1) ? 8'hF0 : seed[7:0];
      acc(1'b1, 8'h13, d);
      chk("wipe", {4'h0, d[3:0]}, {4'h0, wipe_o});
      @(posedge clk_i);
      #1;
      chk("wipe end", 8'h00, {4'h0, wipe_o});
      rd(8'h13, 8'h00);
    end
    $display("test temperature clear done");
    fire(2);
    fire(3);
    mode(1'b0);
    acc(1'b1, 8'h14, 8'h03);
    st("err i2c");
    mode(1'b1);
    acc(1'b1, 8'h14, 8'hFE);
    pec_m = 1'b0;
    st("err pec");
    acc(1'b1, 8'h14, 8'h01);
    tbit_m = 1'b0;
    st("err tbit");
    rd(8'h14, 8'h00);
    $display("test error clear done");
    for (int b = 0; b < 2; b++) begin
      wcfg(8'hC0);
      fire(b);
    end
    rd(8'h20, 8'h00);
    acc(1'b1, 8'h20, 8'hFF);
    rd(8'h12, cfg_m | 8'h20);
    $display("test reset events done");
    end_of_test();
  end
endmodule : tb_sensor_cfg_regs
